// >>> common/tbirq_map.svh
`ifndef TBIRQ_MAP_SVH
`define TBIRQ_MAP_SVH

// register address on the internal management port
`define TBIRQ_ADDR_CTRL    8'h12
// implemented field reset value and unimplemented upper bits
`define TBIRQ_CTRL_RST     5'h00
`define TBIRQ_UNUSED_ZERO  3'h0
`define TBIRQ_RDATA_IDLE   8'h00
`define TBIRQ_SYNC_RST     1'h0

`endif

// >>> common/tbirq_pkg.sv
`default_nettype none

package tbirq_pkg;

	// field order gives bit 4 down to bit 0 of the control register
	typedef struct packed {
		logic backup_switch_irq_en;
		logic temp_high_detect_en;
		logic temp_low_detect_en;
		logic temp_high_irq_en;
		logic temp_low_irq_en;
	} tbirq_ctrl_t;

	// management port request as seen by the register bank
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} tbirq_req_t;

	typedef struct packed {
		tbirq_ctrl_t ctrl;
		logic        backup_switch_flag;
		logic        sw_level_prev;
		logic [7:0]  rdata;
		logic        int_n;
		logic        temp_high_hit;
		logic        temp_low_hit;
	} tbirq_state_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} tbirq_sync_t;

endpackage : tbirq_pkg

`default_nettype wire

// >>> rtl/tbirq_reg.sv
`timescale 1ns/1ns
`default_nettype none
`include "tbirq_map.svh"

// How it works
// [RULE1] control register at 0x12, five enable bits
// [RULE2] reads always work; writes blocked by protection
// [RULE3] switchover interrupt disabled: output released, default
// [RULE4] switchover interrupt enabled: switchover drives int_n low
// [RULE5] int_n held until switchover flag cleared
// [RULE6] high detect disabled: no high detection, default
// [RULE7] high detect enabled: compare against high threshold
// [RULE8] stop bit halts all temperature comparison
// [RULE9] bits 7..5 read zero; reset clears all
module tbirq_reg
	import tbirq_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	input  wire logic        write_protect,
	input  wire logic        stop_bit,
	input  wire logic        backup_switch_in,
	input  wire logic        backup_switch_flag_clr,
	input  wire logic [7:0]  temp_meas,
	input  wire logic [7:0]  high_temp_threshold,
	input  wire logic [7:0]  low_temp_threshold,
	output logic             backup_switch_flag,
	output logic             int_n,
	output logic             temp_high_hit,
	output logic             temp_low_hit,
	output logic             temp_high_irq_en,
	output logic             temp_low_irq_en
);

	// whole register state lives in one struct so reset and update stay in one place
	// hazard: any field added to the state must also be given a value in the reset branch
	tbirq_state_t st;
	tbirq_state_t next_st;
	// request bundle; address decode and write gating are plain logic, no extra latency
	tbirq_req_t   req;
	logic         sw_level;
	logic         hit;
	logic         wr_ok;
	logic         sw_rise;

	// the switchover detector sits in the analog power domain, so its level is resynchronised
	tbirq_sync u_sync (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.async_in (backup_switch_in),
		.level    (sw_level)
	);

	// decode of the management port request
	// write protection is a level from the password logic, sampled in the write cycle itself
	// edge detect on the synchronised level; prev resets low to match the idle pin
	assign req     = '{addr: reg_addr, wr: reg_wr, rd: reg_rd, wdata: reg_wdata};
	assign hit     = (req.addr == `TBIRQ_ADDR_CTRL);             // see [RULE1]
	assign wr_ok   = req.wr && hit && !write_protect;            // see [RULE2]
	assign sw_rise = sw_level && !st.sw_level_prev;

	always_comb begin
		next_st               = st;
		next_st.sw_level_prev = sw_level;
		// write path; upper bits of the write data are simply dropped
		if (wr_ok) begin
			next_st.ctrl = tbirq_ctrl_t'(req.wdata[4:0]);            // see [RULE1] see [RULE9]
		end
		// read returns the contents before a same-cycle write lands
		if (req.rd && hit) begin
			next_st.rdata = {`TBIRQ_UNUSED_ZERO, st.ctrl};           // see [RULE2] see [RULE9]
		end else if (req.rd) begin
			next_st.rdata = `TBIRQ_RDATA_IDLE;
		end
		// set wins over clear so a switchover in the clear cycle is not lost
		if (sw_rise) begin
			next_st.backup_switch_flag = 1'b1;
		end else if (backup_switch_flag_clr) begin
			next_st.backup_switch_flag = 1'b0;                      // see [RULE5]
		end
		// no self-clearing path: only the flag or the enable releases the pin
		next_st.int_n = !(next_st.ctrl.backup_switch_irq_en
			&& next_st.backup_switch_flag);                          // see [RULE3] see [RULE4] see [RULE5]
		// comparisons are frozen low while stopped, the enable alone gates them otherwise
		next_st.temp_high_hit = next_st.ctrl.temp_high_detect_en && !stop_bit
			&& ($signed(temp_meas) > $signed(high_temp_threshold));  // see [RULE6] see [RULE7] see [RULE8]
		next_st.temp_low_hit  = next_st.ctrl.temp_low_detect_en && !stop_bit
			&& ($signed(temp_meas) < $signed(low_temp_threshold));   // see [RULE8]
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '{ctrl: tbirq_ctrl_t'(`TBIRQ_CTRL_RST), backup_switch_flag: 1'b0, sw_level_prev: 1'b0,
				rdata: `TBIRQ_RDATA_IDLE, int_n: 1'b1, temp_high_hit: 1'b0, temp_low_hit: 1'b0}; // see [RULE9]
		end else begin
			st <= next_st;
		end
	end

	// every output is a flip-flop of the state
	assign reg_rdata          = st.rdata;
	assign backup_switch_flag = st.backup_switch_flag;
	assign int_n              = st.int_n;
	assign temp_high_hit      = st.temp_high_hit;
	assign temp_low_hit       = st.temp_low_hit;
	assign temp_high_irq_en   = st.ctrl.temp_high_irq_en;
	assign temp_low_irq_en    = st.ctrl.temp_low_irq_en;

	// checks below all run on mclk and are muted while reset is held
	// several of them exclude a same-cycle write, which legally moves the enables
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence s_wr_free;
		wr_ok;
	endsequence

	sequence s_switch_seen;
		sw_rise ##1 backup_switch_flag;
	endsequence

	write_takes_a: assert property (s_wr_free |=> st.ctrl == $past(reg_wdata[4:0])) // see [RULE1]
		else $error("unprotected write did not land");
	write_block_a: assert property (reg_wr && hit && write_protect |=> $stable(st.ctrl)) // see [RULE2]
		else $error("protected write changed the register");
	read_back_a: assert property (reg_rd && hit |=> reg_rdata == {`TBIRQ_UNUSED_ZERO, $past(st.ctrl)}) // see [RULE2]
		else $error("read data differs from contents");
	bs_masked_a: assert property (!st.ctrl.backup_switch_irq_en |-> int_n) // see [RULE3]
		else $error("int_n low with switchover interrupt off");
	bs_fires_a: assert property (st.ctrl.backup_switch_irq_en && !wr_ok ##0 s_switch_seen |-> !int_n) // see [RULE4]
		else $error("switchover did not pull int_n low");
	bs_held_a: assert property (!int_n && !backup_switch_flag_clr && !wr_ok |=> !int_n) // see [RULE5]
		else $error("int_n released without flag clear");
	flag_set_a: assert property (sw_rise && backup_switch_flag_clr |=> backup_switch_flag) // see [RULE5]
		else $error("clear beat a same-cycle switchover");
	hi_off_a: assert property (!st.ctrl.temp_high_detect_en && !wr_ok |=> !temp_high_hit) // see [RULE6]
		else $error("high detect while disabled");
	hi_cmp_a: assert property (st.ctrl.temp_high_detect_en && !stop_bit && !wr_ok
		&& $signed(temp_meas) > $signed(high_temp_threshold) |=> temp_high_hit) // see [RULE7]
		else $error("high compare missed");
	stop_halt_a: assert property (stop_bit |=> !temp_high_hit && !temp_low_hit) // see [RULE8]
		else $error("detection while stopped");
	upper_zero_a: assert property (reg_rdata[7:5] == `TBIRQ_UNUSED_ZERO) // see [RULE9]
		else $error("unimplemented bits read nonzero");

	// a host clear with no competing switchover in the same cycle
	sequence s_clear_seen;
		backup_switch_flag_clr && !sw_rise;
	endsequence

	// a write that turns the switchover interrupt off
	sequence s_mask_write;
		wr_ok && !req.wdata[4];
	endsequence

	// the clear drops the sticky flag on the next edge
	bs_clear_a: assert property (s_clear_seen |=> !backup_switch_flag) // see [RULE5]
		else $error("flag survived a clear");

	// the clear also releases the interrupt pin
	int_release_a: assert property (s_clear_seen |=> int_n) // see [RULE5]
		else $error("int_n stayed low after clear");

	// writing the enable to zero withdraws the interrupt
	bs_mask_off_a: assert property (s_mask_write |=> int_n) // see [RULE3]
		else $error("int_n low after enable cleared");

	// the flag never clears by itself
	flag_sticky_a: assert property (backup_switch_flag && !backup_switch_flag_clr |=> backup_switch_flag) // see [RULE5]
		else $error("flag released without clear");

	// only a switchover edge may set the flag
	no_spur_flag_a: assert property (!backup_switch_flag && !sw_rise |=> !backup_switch_flag) // see [RULE4]
		else $error("flag set without switchover");

	// a high compare that does not hold leaves the result low
	hi_quiet_a: assert property (st.ctrl.temp_high_detect_en && !wr_ok
		&& !($signed(temp_meas) > $signed(high_temp_threshold)) |=> !temp_high_hit) // see [RULE7]
		else $error("high hit without exceedance");

	// low detect disabled keeps the low result low
	lo_off_a: assert property (!st.ctrl.temp_low_detect_en && !wr_ok |=> !temp_low_hit) // see [RULE1]
		else $error("low detect while disabled");

	// low compare enabled and running catches a reading below threshold
	lo_cmp_a: assert property (st.ctrl.temp_low_detect_en && !stop_bit && !wr_ok
		&& $signed(temp_meas) < $signed(low_temp_threshold) |=> temp_low_hit) // see [RULE1]
		else $error("low compare missed");

	// the two interrupt enable outputs follow the written bits
	irq_en_out_a: assert property (wr_ok |=> {temp_high_irq_en, temp_low_irq_en} == $past(reg_wdata[1:0])) // see [RULE1]
		else $error("interrupt enable outputs wrong");

	// a read of another address returns the idle value
	rd_miss_a: assert property (reg_rd && !hit |=> reg_rdata == `TBIRQ_RDATA_IDLE) // see [RULE1]
		else $error("foreign read returned data");

	// read data stands until the next read strobe
	rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) // see [RULE2]
		else $error("read data moved without read");

	// a write to another address leaves the register alone
	wr_miss_a: assert property (reg_wr && !hit |=> $stable(st.ctrl)) // see [RULE1]
		else $error("foreign write changed the register");

	// stop halts the low compare too, even with the enable set
	stop_low_a: assert property (stop_bit && st.ctrl.temp_low_detect_en |=> !temp_low_hit) // see [RULE8]
		else $error("low detection while stopped");

endmodule : tbirq_reg

`default_nettype wire

// >>> rtl/tbirq_sync.sv
`timescale 1ns/1ns
`default_nettype none
`include "tbirq_map.svh"

module tbirq_sync
	import tbirq_pkg::*;
(
	input  wire logic mclk,
	input  wire logic sys_rst,
	input  wire logic async_in,
	output logic      level
);

	tbirq_sync_t st;
	tbirq_sync_t next_st;

	// the level only moves once stages two and three agree, filtering a one-stage glitch
	always_comb begin
		next_st    = st;
		next_st.s1 = async_in;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		if (st.s2 == st.s3) begin
			next_st.level = st.s3;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '{s1: `TBIRQ_SYNC_RST, s2: `TBIRQ_SYNC_RST, s3: `TBIRQ_SYNC_RST, level: `TBIRQ_SYNC_RST};
		end else begin
			st <= next_st;
		end
	end

	assign level = st.level;

endmodule : tbirq_sync

`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
	import tbirq_pkg::*;
;
	logic       mclk, sys_rst, write_protect, stop_bit, sw_pin, reg_wr, reg_rd, flag_clr;
	logic       flag, int_n, hi_hit, lo_hit, hi_ie, lo_ie;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, temp_meas, thr_hi, thr_lo;
	int         err_total, n_compared;

	tbirq_host_model i_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .flag_clr(flag_clr));
	tbirq_reg i_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .write_protect(write_protect), .stop_bit(stop_bit),
		.backup_switch_in(sw_pin), .backup_switch_flag_clr(flag_clr), .temp_meas(temp_meas),
		.high_temp_threshold(thr_hi), .low_temp_threshold(thr_lo), .backup_switch_flag(flag),
		.int_n(int_n), .temp_high_hit(hi_hit), .temp_low_hit(lo_hit), .temp_high_irq_en(hi_ie),
		.temp_low_irq_en(lo_ie));

	// 25 MHz
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task automatic wrap_up();
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// inputs and samples both sit just after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		i_host.rd(a);
		chk("rdata", reg_rdata, exp);
	endtask : rd_chk
	// bounded wait for the synchronised switchover to reach the flag
	task automatic wait_flag();
		for (int i = 0; i < 12 && flag !== 1'b1; i++) tick(1);
		if (flag !== 1'b1) begin
			err_total++;
			wrap_up();
		end
	endtask : wait_flag
	task automatic t_rw();
		chk("int_n", 8'(int_n), 8'h01);
		rd_chk(8'h12, 8'h00);
		i_host.wr(8'h12, 8'hff);
		chk("irq_en", 8'({hi_ie, lo_ie}), 8'h03);
		rd_chk(8'h12, 8'h1f);
		rd_chk(8'h13, 8'h00);
		write_protect = 1'b1;
		i_host.wr(8'h12, 8'h00);
		rd_chk(8'h12, 8'h1f);
		write_protect = 1'b0;
		i_host.wr(8'h12, 8'h0a);
		rd_chk(8'h12, 8'h0a);
		chk("irq_en", 8'({hi_ie, lo_ie}), 8'h02);
		$display("test register port done");
	endtask : t_rw
	task automatic t_temp();
		temp_meas = 8'h10;
		tick(2);
		chk("hi_hit", 8'(hi_hit), 8'h00);
		temp_meas = 8'h20;
		tick(2);
		chk("hi_hit", 8'(hi_hit), 8'h01);
		stop_bit = 1'b1;
		tick(2);
		chk("hi_hit", 8'(hi_hit), 8'h00);
		stop_bit = 1'b0;
		i_host.wr(8'h12, 8'h04);
		tick(2);
		chk("hi_hit", 8'(hi_hit), 8'h00);
		temp_meas = 8'he0;
		tick(2);
		chk("lo_hit", 8'(lo_hit), 8'h01);
		$display("test temperature done");
	endtask : t_temp
	task automatic t_sw();
		i_host.wr(8'h12, 8'h10);
		sw_pin = 1'b1;
		wait_flag();
		chk("int_n", 8'(int_n), 8'h00);
		tick(6);
		chk("int_n", 8'(int_n), 8'h00);
		i_host.clr();
		chk("flag_int", 8'({flag, int_n}), 8'h01);
		sw_pin = 1'b0;
		i_host.wr(8'h12, 8'h00);
		tick(4);
		sw_pin = 1'b1;
		wait_flag();
		tick(2);
		chk("int_n", 8'(int_n), 8'h01);
		$display("test switchover done");
	endtask : t_sw
	initial begin
		err_total = 0;
		n_compared = 0;
		sys_rst = 1'b1;
		write_protect = 1'b0;
		stop_bit = 1'b0;
		sw_pin = 1'b0;
		temp_meas = 8'h00;
		thr_hi = 8'h10;
		thr_lo = 8'hf0;
		repeat (8) @(posedge mclk);
		#1 sys_rst = 1'b0;
		t_rw();
		t_temp();
		t_sw();
		wrap_up();
	end
endmodule : tb
`default_nettype wire

// >>> sim/tbirq_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// host side of the management port; strobes are one-cycle pulses
module tbirq_host_model (
	input  wire logic       mclk,
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_wdata,
	output logic            flag_clr
);
	// quiet port at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
		flag_clr = 1'b0;
	end
	// one write; address and data inverted after release so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1 reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge mclk);
		#1 reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : wr
	// one read; data lands at the taking edge
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		#1 reg_addr = a;
		reg_rd = 1'b1;
		@(posedge mclk);
		#1 reg_rd = 1'b0;
		reg_addr = ~a;
	endtask : rd
	// the interrupt goes away when the host clears the flag or writes the switchover enable to zero
	task automatic clr();
		@(posedge mclk);
		#1 flag_clr = 1'b1;
		@(posedge mclk);
		#1 flag_clr = 1'b0;
	endtask : clr
endmodule : tbirq_host_model
`default_nettype wire
